// [common/cfgprog_defines.svh]
`ifndef CFGPROG_DEFINES_SVH
`define CFGPROG_DEFINES_SVH

// ****************************************************************
// instruction codes
// ****************************************************************
`define IR_EXTEST               8'h00
`define IR_ADDRESS_SHIFT        8'h01
`define IR_DATA_SHIFT           8'h02
`define IR_WIPE                 8'h03
`define IR_COLUMN_WRITE         8'h07
`define IR_LOCK_SET             8'h09
`define IR_COLUMN_READBACK      8'h0A
`define IR_SUPPLY_BLEED         8'h14
`define IR_PROG_ENTER           8'h15
`define IR_IDENT                8'h16
`define IR_USER_SIGNATURE_FETCH 8'h17
`define IR_HIGHZ                8'h18
`define IR_USER_SIGNATURE_STORE 8'h1A
`define IR_SAMPLE               8'h1C
`define IR_PROG_LEAVE           8'h1E
`define IR_CLAMP                8'h20
`define IR_DONE_CLEAR           8'h24
`define IR_COLUMN_WRITE_ADVANCE 8'h27
`define IR_COLUMN_READ_ADVANCE  8'h2A
`define IR_INTEST               8'h2C
`define IR_DONE_SET             8'h2F
`define IR_IDLE_HOLD_CMD        8'h30

// ****************************************************************
// widths and reset values
// ****************************************************************
`define IR_W          8
`define ADDR_W        10
`define COL_W_SMALL   43
`define COL_W_LARGE   61
`define SIG_W         32
`define IR_CAPTURE    8'h01
`define IR_RESET      8'h16
`define CORE_RESET    32'h0000_0000

// ****************************************************************
// ahb register offsets and status fields
// ****************************************************************
`define OFF_STATUS    12'h000
`define OFF_CORE_OUT  12'h004
`define OFF_CORE_OE   12'h008
`define OFF_ADDRESS   12'h00C
`define ST_PROG       0
`define ST_LOCK       1
`define ST_DONE       2
`define ST_CHARGED    3
`define ST_BUSY       4
`define ST_IR_LSB     8

`endif

// [common/cfgprog_pkg.sv]
package cfgprog_pkg;

  typedef enum logic [15:0] {
    TAP_RESET   = 16'h0001,
    TAP_IDLE    = 16'h0002,
    DR_SELECT   = 16'h0004,
    DR_CAPTURE  = 16'h0008,
    DR_SHIFT    = 16'h0010,
    DR_EXIT1    = 16'h0020,
    DR_PAUSE    = 16'h0040,
    DR_EXIT2    = 16'h0080,
    DR_UPDATE   = 16'h0100,
    IR_SELECT   = 16'h0200,
    IR_CAPTURE  = 16'h0400,
    IR_SHIFT    = 16'h0800,
    IR_EXIT1    = 16'h1000,
    IR_PAUSE    = 16'h2000,
    IR_EXIT2    = 16'h4000,
    IR_UPDATE   = 16'h8000
  } tap_state_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
  } ahb_req_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtag_pins_t;

endpackage : cfgprog_pkg

// [verilog/column_store.sv]
module column_store #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 43
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  input  wire logic              clear_start,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   clear_busy
);

  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [ADDR_W-1:0] sweep;

  // clearing walks every column, one per cycle, so no wide reset net is needed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clear_busy <= 1'b0;
      sweep      <= '0;
    end else if (clear_start && !clear_busy) begin
      clear_busy <= 1'b1;
      sweep      <= '0;
    end else if (clear_busy) begin
      sweep <= sweep + 1'b1;
      if (sweep == {ADDR_W{1'b1}}) begin
        clear_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk) begin
    if (clear_busy) begin
      mem[sweep] <= '0;
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : column_store

// [verilog/cfg_jtag_programmer.sv]
// Operation
// - entry instruction, once updated into IR, turns programming mode on.
// - exit instruction, once updated into IR, turns programming mode off.
// - wipe clears every column, the stored signature and the lock fuse.
// - address shift puts a 10-bit address register between TDI and TDO.
// - data shift connects the column register, 43 or 61 bits, both ways.
// - column write stores the column register at the addressed column.
// - column write with advance stores, then increments the address.
// - with the lock fuse set only ident and signature are read out; here the address, boundary and bypass registers still shift out.
// - the lock fuse clears only by a wipe.
// - column readback loads the addressed column into the column register.
// - readback with advance loads the column, then increments the address.
// - wipe, writes, lock, readbacks, signature store need programming mode.
// - supply bleed discharges the programming supply after erase or write.
// - signature store writes the 32-bit signature register to memory.
// - signature fetch loads the stored signature and selects its register.
// - HIGHZ puts every output pin in high impedance.
// - CLAMP drives the pins from the boundary scan register.
// - done-clear clears only the completion bit, disabling normal outputs.
// - done-set sets only the completion bit, enabling normal outputs.
// - the idle hold instruction behaves like CLAMP.
// - instruction register and codes are eight bits.
// - any code with its top bit set selects the one-bit bypass register.
//
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`include "cfgprog_defines.svh"

module cfg_jtag_programmer #(
  parameter int          COL_W  = `COL_W_SMALL,
  parameter int          NPINS  = 4,
  parameter logic [31:0] IDENT  = 32'h0000_0001  // arbitrary value
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire cfgprog_pkg::ahb_req_t ahb_req,
  input  wire logic                  hready,
  input  wire logic [31:0]           hwdata,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire cfgprog_pkg::jtag_pins_t jtag,
  output logic                       tdo,
  output logic                       tdo_oe,
  input  wire logic [NPINS-1:0]      pin_in,
  output logic      [NPINS-1:0]      pin_out,
  output logic      [NPINS-1:0]      pin_oe
);
  import cfgprog_pkg::*;

  localparam int BSR_W = 3 * NPINS;

  if (!(COL_W == `COL_W_SMALL || COL_W == `COL_W_LARGE) || NPINS < 1 || NPINS > 32) begin : g_param_check
    $error("cfg_jtag_programmer: unsupported COL_W or NPINS");
  end

  // ****************************************************************
  // pin synchronisers and tck edges
  // ****************************************************************
  jtag_pins_t         jtag_s1;
  jtag_pins_t         jtag_s2;
  logic               tck_d;
  logic [NPINS-1:0]   pin_s1;
  logic [NPINS-1:0]   pin_s2;
  logic               tck_rise;
  logic               tck_fall;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      jtag_s1 <= '0;
      jtag_s2 <= '0;
      tck_d   <= 1'b0;
      pin_s1  <= '0;
      pin_s2  <= '0;
    end else begin
      jtag_s1 <= jtag;
      jtag_s2 <= jtag_s1;
      tck_d   <= jtag_s2.tck;
      pin_s1  <= pin_in;
      pin_s2  <= pin_s1;
    end
  end

  assign tck_rise = jtag_s2.tck && !tck_d;
  assign tck_fall = !jtag_s2.tck && tck_d;

  // ****************************************************************
  // tap controller
  // ****************************************************************
  tap_state_t state;
  tap_state_t next_state;
  logic       tms;

  assign tms = jtag_s2.tms;

  always_comb begin
    case (state)
      TAP_RESET:  next_state = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:   next_state = tms ? DR_SELECT : TAP_IDLE;
      DR_SELECT:  next_state = tms ? IR_SELECT : DR_CAPTURE;
      DR_CAPTURE: next_state = tms ? DR_EXIT1 : DR_SHIFT;
      DR_SHIFT:   next_state = tms ? DR_EXIT1 : DR_SHIFT;
      DR_EXIT1:   next_state = tms ? DR_UPDATE : DR_PAUSE;
      DR_PAUSE:   next_state = tms ? DR_EXIT2 : DR_PAUSE;
      DR_EXIT2:   next_state = tms ? DR_UPDATE : DR_SHIFT;
      DR_UPDATE:  next_state = tms ? DR_SELECT : TAP_IDLE;
      IR_SELECT:  next_state = tms ? TAP_RESET : IR_CAPTURE;
      IR_CAPTURE: next_state = tms ? IR_EXIT1 : IR_SHIFT;
      IR_SHIFT:   next_state = tms ? IR_EXIT1 : IR_SHIFT;
      IR_EXIT1:   next_state = tms ? IR_UPDATE : IR_PAUSE;
      IR_PAUSE:   next_state = tms ? IR_EXIT2 : IR_PAUSE;
      IR_EXIT2:   next_state = tms ? IR_UPDATE : IR_SHIFT;
      IR_UPDATE:  next_state = tms ? DR_SELECT : TAP_IDLE;
      default:    next_state = TAP_RESET;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= TAP_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // instruction register
  // ****************************************************************
  logic [`IR_W-1:0] ir_shift;
  logic [`IR_W-1:0] ir;
  logic             ir_load;

  assign ir_load = tck_rise && state == IR_UPDATE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_shift <= `IR_CAPTURE;
      ir       <= `IR_RESET;
    end else if (tck_rise) begin
      case (state)
        TAP_RESET:  ir <= `IR_RESET;
        IR_CAPTURE: ir_shift <= `IR_CAPTURE;
        IR_SHIFT:   ir_shift <= {jtag_s2.tdi, ir_shift[`IR_W-1:1]};
        IR_UPDATE:  ir <= ir_shift;
        default:    ir <= ir;
      endcase
    end
  end

  // ****************************************************************
  // instruction execution
  // ****************************************************************
  logic               prog_mode;
  logic               lock_fuse;
  logic               done_bit;
  logic               charged;
  logic               mem_busy;
  logic               exec;
  logic               exec_prog;
  logic               rd_pend;
  logic [`ADDR_W-1:0] addr_reg;
  logic [COL_W-1:0]   col_reg;
  logic [COL_W-1:0]   mem_rd;
  logic [`SIG_W-1:0]  sig_reg;
  logic [`SIG_W-1:0]  sig_stored;
  logic               do_wipe;
  logic               do_write;
  logic               do_read;
  logic               do_advance;

  // operations fire once on each entry to run-test/idle; a clear sweep in
  // progress swallows them, so the host must idle long enough after a wipe
  assign exec_prog = exec && prog_mode;
  assign do_wipe   = exec_prog && ir == `IR_WIPE;
  assign do_write  = exec_prog && (ir == `IR_COLUMN_WRITE || ir == `IR_COLUMN_WRITE_ADVANCE);
  assign do_read   = exec_prog && (ir == `IR_COLUMN_READBACK || ir == `IR_COLUMN_READ_ADVANCE);
  assign do_advance = exec_prog && (ir == `IR_COLUMN_WRITE_ADVANCE || ir == `IR_COLUMN_READ_ADVANCE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_mode <= 1'b0;
    end else if (ir_load && ir_shift == `IR_PROG_ENTER) begin
      prog_mode <= 1'b1;
    end else if (ir_load && ir_shift == `IR_PROG_LEAVE) begin
      prog_mode <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_fuse  <= 1'b0;
      done_bit   <= 1'b0;
      sig_stored <= '0;
    end else if (do_wipe) begin
      lock_fuse  <= 1'b0;
      done_bit   <= 1'b0;
      sig_stored <= '0;
    end else if (exec_prog) begin
      case (ir)
        `IR_LOCK_SET:             lock_fuse <= 1'b1;
        `IR_USER_SIGNATURE_STORE: sig_stored <= sig_reg;
        `IR_DONE_CLEAR:           done_bit <= 1'b0;
        `IR_DONE_SET:             done_bit <= 1'b1;
        default:                  done_bit <= done_bit;
      endcase
    end
  end

  // the programming supply counts as charged after any erase or write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      charged <= 1'b0;
    end else if (do_wipe || do_write || (exec_prog && ir == `IR_USER_SIGNATURE_STORE)) begin
      charged <= 1'b1;
    end else if (exec && ir == `IR_SUPPLY_BLEED) begin
      charged <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend <= 1'b0;
      exec    <= 1'b0;
    end else begin
      rd_pend <= do_read;
      // one hclk late, so an instruction loaded at the same tck edge is the one decoded
      exec    <= tck_rise && next_state == TAP_IDLE && state != TAP_IDLE && !mem_busy;
    end
  end

  column_store #(
    .ADDR_W (`ADDR_W),
    .DATA_W (COL_W)
  ) u_store (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .wr_en       (do_write),
    .wr_addr     (addr_reg),
    .wr_data     (col_reg),
    .rd_en       (do_read),
    .rd_addr     (addr_reg),
    .clear_start (do_wipe),
    .rd_data     (mem_rd),
    .clear_busy  (mem_busy)
  );

  // ****************************************************************
  // data registers
  // ****************************************************************
  logic [`SIG_W-1:0] id_reg;
  logic [BSR_W-1:0]  bsr;
  logic [BSR_W-1:0]  bsr_upd;
  logic              bypass_reg;
  logic              sel_bsr;
  logic              dr_cap;
  logic              dr_sh;
  logic              tdi;

  assign tdi     = jtag_s2.tdi;
  assign dr_cap  = tck_rise && state == DR_CAPTURE;
  assign dr_sh   = tck_rise && state == DR_SHIFT;
  assign sel_bsr = !ir[7] && (ir == `IR_EXTEST || ir == `IR_SAMPLE || ir == `IR_CLAMP
                   || ir == `IR_INTEST || ir == `IR_IDLE_HOLD_CMD);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= '0;
    end else if (do_advance) begin
      addr_reg <= addr_reg + 1'b1;
    end else if (dr_sh && ir == `IR_ADDRESS_SHIFT) begin
      addr_reg <= {tdi, addr_reg[`ADDR_W-1:1]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      col_reg <= '0;
    end else if (rd_pend) begin
      col_reg <= lock_fuse ? '0 : mem_rd;
    end else if (dr_sh && ir == `IR_DATA_SHIFT) begin
      col_reg <= {tdi, col_reg[COL_W-1:1]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sig_reg <= '0;
    end else if (ir_load && ir_shift == `IR_USER_SIGNATURE_FETCH) begin
      sig_reg <= sig_stored;
    end else if (dr_sh && (ir == `IR_USER_SIGNATURE_FETCH || ir == `IR_USER_SIGNATURE_STORE)) begin
      sig_reg <= {tdi, sig_reg[`SIG_W-1:1]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      id_reg     <= '0;
      bypass_reg <= 1'b0;
    end else if (dr_cap) begin
      id_reg     <= IDENT;
      bypass_reg <= 1'b0;
    end else if (dr_sh) begin
      id_reg     <= {tdi, id_reg[`SIG_W-1:1]};
      bypass_reg <= tdi;
    end
  end

  // boundary cells: inputs at the top, then output values, then enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bsr     <= '0;
      bsr_upd <= '0;
    end else if (sel_bsr && dr_cap) begin
      bsr <= {pin_s2, pin_out, pin_oe};
    end else if (sel_bsr && dr_sh) begin
      bsr <= {tdi, bsr[BSR_W-1:1]};
    end else if (sel_bsr && tck_rise && state == DR_UPDATE) begin
      bsr_upd <= bsr;
    end
  end

  // ****************************************************************
  // tdo on the falling tck edge
  // ****************************************************************
  logic tdo_bit;

  always_comb begin
    tdo_bit = bypass_reg;
    if (state == IR_SHIFT) begin
      tdo_bit = ir_shift[0];
    end else if (!ir[7]) begin
      case (ir)
        `IR_ADDRESS_SHIFT:        tdo_bit = addr_reg[0];
        `IR_DATA_SHIFT:           tdo_bit = col_reg[0] && !lock_fuse;
        `IR_IDENT:                tdo_bit = id_reg[0];
        `IR_USER_SIGNATURE_FETCH: tdo_bit = sig_reg[0];
        `IR_USER_SIGNATURE_STORE: tdo_bit = sig_reg[0];
        default:                  tdo_bit = sel_bsr ? bsr[0] : bypass_reg;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= tdo_bit;
      tdo_oe <= state == IR_SHIFT || state == DR_SHIFT;
    end
  end

  // ****************************************************************
  // output pins
  // ****************************************************************
  logic [31:0] core_out;
  logic [31:0] core_oe;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else if (ir == `IR_HIGHZ) begin
      pin_oe <= '0;
    end else if (ir == `IR_CLAMP || ir == `IR_IDLE_HOLD_CMD || ir == `IR_EXTEST || ir == `IR_INTEST) begin
      pin_out <= bsr_upd[2*NPINS-1:NPINS];
      pin_oe  <= bsr_upd[NPINS-1:0];
    end else begin
      pin_out <= core_out[NPINS-1:0];
      pin_oe  <= (done_bit && !prog_mode) ? core_oe[NPINS-1:0] : '0;
    end
  end

  // ****************************************************************
  // ahb-lite register slave
  // ****************************************************************
  logic        wr_pend;
  logic [11:0] wr_off;
  logic        acc;
  logic [11:0] off;
  logic [31:0] rd_val;

  assign acc = ahb_req.hsel && ahb_req.htrans[1] && hready;
  assign off = ahb_req.haddr[11:0];

  always_comb begin
    case (off)
      `OFF_STATUS:   rd_val = {16'h0000, ir, 3'b000, mem_busy, charged, done_bit, lock_fuse, prog_mode};
      `OFF_CORE_OUT: rd_val = core_out;
      `OFF_CORE_OE:  rd_val = core_oe;
      `OFF_ADDRESS:  rd_val = {22'h00_0000, addr_reg};
      default:       rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_off    <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend <= acc && ahb_req.hwrite;
      wr_off  <= off;
      if (acc && !ahb_req.hwrite) begin
        hrdata <= rd_val;
      end
    end
  end

  // only the low NPINS bits of the pin registers are kept; the rest read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_out <= `CORE_RESET;
      core_oe  <= `CORE_RESET;
    end else if (wr_pend && wr_off == `OFF_CORE_OUT) begin
      core_out <= hwdata & {{(32-NPINS){1'b0}}, {NPINS{1'b1}}};
    end else if (wr_pend && wr_off == `OFF_CORE_OE) begin
      core_oe <= hwdata & {{(32-NPINS){1'b0}}, {NPINS{1'b1}}};
    end
  end

endmodule : cfg_jtag_programmer

// [bench/cfg_jtag_programmer_props.sv]
module cfg_prog_props #(
  parameter int NPINS = 4
) (
  input wire logic                    hclk,
  input wire logic                    hresetn,
  input wire cfgprog_pkg::ahb_req_t   ahb_req,
  input wire logic                    hready,
  input wire logic [31:0]             hwdata,
  input wire logic [31:0]             hrdata,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  input wire cfgprog_pkg::jtag_pins_t jtag,
  input wire logic                    tdo,
  input wire logic                    tdo_oe,
  input wire logic [NPINS-1:0]        pin_in,
  input wire logic [NPINS-1:0]        pin_out,
  input wire logic [NPINS-1:0]        pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  import cfgprog_pkg::*;
  // ********
  // link and bus checks
  // ********
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_bus_ready: assert property (hreadyout)
    else $error("bus wait state seen");
  a_bus_okay: assert property (!hresp)
    else $error("bus error response seen");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(ahb_req.hsel && ahb_req.htrans[1] && !ahb_req.hwrite && hready))
    else $error("read data moved without a read");
  a_tdo_at_fall: assert property ($changed(tdo) |-> !$past(jtag.tck, 3))
    else $error("tdo moved away from a tck fall");
  a_oe_at_fall: assert property ($changed(tdo_oe) |-> !$past(jtag.tck, 3))
    else $error("tdo enable moved away from a tck fall");
  a_tdo_stands: assert property ($changed(tdo) |-> ##1 $stable(tdo) [*6])
    else $error("tdo did not stand for a tck period");
  a_oe_min_high: assert property ($rose(tdo_oe) |-> tdo_oe [*4])
    else $error("shift window too short");
  a_oe_min_low: assert property ($fell(tdo_oe) |-> !tdo_oe [*8])
    else $error("shift window reopened too soon");
  c_shift: cover property ($rose(tdo_oe));
  c_pins: cover property ($changed(pin_oe));
  c_read: cover property ($changed(hrdata));
endmodule : cfg_prog_props

bind cfg_jtag_programmer cfg_prog_props #(.NPINS(NPINS)) props_i (
  .hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req), .hready(hready), .hwdata(hwdata),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .jtag(jtag), .tdo(tdo),
  .tdo_oe(tdo_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

// [bench/jtag_host_model.sv]
module jtag_host_model (
  input  wire logic               hclk,
  input  wire logic               tdo,
  output cfgprog_pkg::jtag_pins_t jtag
);
  timeunit 1ns;
  timeprecision 1ns;
  import cfgprog_pkg::*;
  logic b;
  // tdi rests high between frames, as its pull-up would leave it
  initial jtag = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
  // ********
  // one tck period of eight hclk; tdo read late in the high phase
  // ********
  task tick(input logic ms, input logic di, output logic so);
    @(posedge hclk);
    jtag <= '{tck: 1'b0, tms: ms, tdi: di};
    repeat (4) @(posedge hclk);
    jtag.tck <= 1'b1;
    repeat (3) @(posedge hclk);
    so = tdo;
  endtask : tick
  task idle(input int n);
    repeat (n) tick(1'b0, 1'b1, b);
  endtask : idle
  task shift(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
    int i;
    dout = '0;
    tick(1'b1, 1'b1, b);
    if (ir) tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
    tick(1'b0, 1'b1, b);
    for (i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
    tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
  endtask : shift
endmodule : jtag_host_model

// [bench/cfg_jtag_programmer_bench.sv]
module cfg_jtag_programmer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import cfgprog_pkg::*;
  logic hclk, hresetn, hreadyout, hresp, tdo, tdo_oe;
  ahb_req_t ahb_req;
  jtag_pins_t jtag;
  logic [31:0] hwdata, hrdata, d;
  logic [3:0] pin_in, pin_out, pin_oe;
  logic [63:0] o;
  int fails, check_count;
  localparam logic [42:0] D1 = 43'h5A5_1234_5678;
  localparam logic [42:0] D2 = 43'h2C3_9ABC_DEF0;
  localparam logic [31:0] SG = 32'hC3A5_0F96;
  cfg_jtag_programmer uut (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .jtag(jtag), .tdo(tdo),
    .tdo_oe(tdo_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  jtag_host_model host (.hclk(hclk), .tdo(tdo), .jtag(jtag));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // ********
  // shared tasks
  // ********
  task close_out;
    $display("mismatches %0d checks %0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wait_ready;
    int k;
    for (k = 0; k < 16 && hreadyout !== 1'b1; k++) @(posedge hclk);
    if (k == 16) begin
      fails++;
      close_out;
    end
  endtask : wait_ready
  task bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    ahb_req <= '{1'b1, {20'h0_0000, a}, 2'b10, w, 3'b010};
    @(posedge hclk);
    wait_ready;
    ahb_req.htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    wait_ready;
    rd = hrdata;
  endtask : bus
  task st(input int b, input logic e);
    logic [31:0] v;
    bus(1'b0, 12'h000, 32'h0000_0000, v);
    chk(v[b], e);
  endtask : st
  task ir(input logic [7:0] c);
    logic [63:0] r;
    host.shift(1'b1, 8, c, r);
    // let the update and the operation it starts settle before anyone looks
    repeat (3) @(posedge hclk);
    chk(r, 8'h01);
  endtask : ir
  task dr(input int n, input logic [63:0] v);
    host.shift(1'b0, n, v, o);
  endtask : dr
  task wipe;
    ir(8'h03);
    host.idle(130);
  endtask : wipe
  task colw(input logic [7:0] c, input logic [9:0] a, input logic [42:0] v);
    ir(8'h01);
    dr(10, a);
    ir(8'h02);
    dr(43, v);
    ir(c);
  endtask : colw
  task colr(input logic [7:0] c, input logic [9:0] a);
    ir(8'h01);
    dr(10, a);
    ir(c);
    ir(8'h02);
    dr(43, 64'h0);
  endtask : colr
  // ********
  // scenarios
  // ********
  task t_bus;
    bus(1'b0, 12'h000, 32'h0, d);
    chk(d, 32'h0000_1600);
    bus(1'b1, 12'h004, 32'h0000_000A, d);
    bus(1'b1, 12'h008, 32'h0000_0005, d);
    bus(1'b1, 12'h00C, 32'h0000_03FF, d);
    bus(1'b1, 12'h010, 32'hFFFF_FFFF, d);
    bus(1'b0, 12'h004, 32'h0, d);
    chk(d, 32'h0000_000A);
    bus(1'b0, 12'h008, 32'h0, d);
    chk(d, 32'h0000_0005);
    bus(1'b0, 12'h00C, 32'h0, d);
    chk(d, 32'h0);
    bus(1'b0, 12'h010, 32'h0, d);
    chk(d, 32'h0);
    chk({pin_out, pin_oe}, 8'hA0);
  endtask : t_bus
  task t_col;
    ir(8'h15);
    st(0, 1'b1);
    wipe;
    ir(8'h14);
    ir(8'h1E);
    st(0, 1'b0);
    colw(8'h07, 10'd5, D1);
    ir(8'h15);
    colr(8'h0A, 10'd5);
    chk(o, 64'h0);
    colw(8'h07, 10'd5, D1);
    st(3, 1'b1);
    ir(8'h14);
    st(3, 1'b0);
    colr(8'h0A, 10'd5);
    chk(o, D1);
    colw(8'h27, 10'd6, D2);
    bus(1'b0, 12'h00C, 32'h0, d);
    chk(d, 32'h0000_0007);
    colr(8'h2A, 10'd6);
    chk(o, D2);
    bus(1'b0, 12'h00C, 32'h0, d);
    chk(d, 32'h0000_0007);
  endtask : t_col
  task t_sig_lock;
    ir(8'h17);
    dr(32, SG);
    ir(8'h1A);
    ir(8'h17);
    dr(32, 64'h0);
    chk(o, SG);
    ir(8'h09);
    st(1, 1'b1);
    colr(8'h0A, 10'd5);
    chk(o, 64'h0);
    ir(8'h17);
    dr(32, 64'h0);
    chk(o, SG);
    ir(8'h16);
    dr(32, 64'h0);
    chk(o, 32'h0000_0001);
    ir(8'h1E);
    ir(8'h15);
    ir(8'h2F);
    st(1, 1'b1);
    wipe;
    st(1, 1'b0);
    st(2, 1'b0);
    colr(8'h0A, 10'd5);
    chk(o, 64'h0);
    ir(8'h17);
    dr(32, 64'h0);
    chk(o, 64'h0);
  endtask : t_sig_lock
  task t_pins;
    logic [7:0] c[3];
    c = '{8'h80, 8'h9C, 8'hFF};
    ir(8'h2F);
    st(2, 1'b1);
    ir(8'h24);
    st(2, 1'b0);
    ir(8'h2F);
    ir(8'h1E);
    chk({pin_out, pin_oe}, 8'hA5);
    ir(8'h18);
    chk({pin_out, pin_oe}, 8'hA0);
    ir(8'h1C);
    dr(12, 12'h0C3);
    chk(o[11:0], 12'h9A5);
    ir(8'h20);
    chk({pin_out, pin_oe}, 8'hC3);
    ir(8'h18);
    ir(8'h30);
    chk({pin_out, pin_oe}, 8'hC3);
    foreach (c[i]) begin
      ir(c[i]);
      dr(8, 8'hA5);
      chk(o, 8'h4A);
    end
  endtask : t_pins
  initial begin
    hresetn = 1'b0;
    ahb_req = '0;
    hwdata = '0;
    pin_in = 4'h9;
    fails = 0;
    check_count = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_bus;
    host.idle(1);
    t_col;
    t_sig_lock;
    t_pins;
    close_out;
  end
endmodule : cfg_jtag_programmer_bench
